//--- pmts_pkg.sv
// Package with register map, field layout and state codes for the test and status bank
package pmts_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATE_MACHINE_STATUS = 8'hE9;
  localparam logic [7:0] ADDR_LOOP_TEST_CONTROL    = 8'hEA;
  localparam logic [7:0] ADDR_BUCK1_TEST_CONTROL   = 8'hF8;
  localparam logic [7:0] ADDR_BUCK3_TEST_CONTROL   = 8'hFA;
  localparam logic [7:0] ADDR_BUCK4_TEST_CONTROL   = 8'hFB;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int USB_STATE_LSB   = 8;
  localparam int USB_STATE_MSB   = 10;
  localparam int CHG_STATE_LSB   = 4;
  localparam int CHG_STATE_MSB   = 6;
  localparam int MAIN_STATE_LSB  = 0;
  localparam int MAIN_STATE_MSB  = 3;
  localparam int FORCE_GAIN_BIT  = 12;
  localparam int BIAS_LSB        = 8;
  localparam int BIAS_MSB        = 9;
  localparam int POLE_LSB        = 6;
  localparam int POLE_MSB        = 7;
  localparam int PWM_FORCE_BIT   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       FORCE_GAIN_RESET = 1'h1;
  localparam logic [1:0] BIAS_RESET       = 2'h2;
  localparam logic [1:0] POLE_RESET       = 2'h0;
  localparam logic       PWM_FORCE_RESET  = 1'h0;
  localparam logic [3:0] TRACK_GAIN_ZERO  = 4'h0;

  // Unlock key value; arbitrary, held as a fixed package localparam
  localparam logic [15:0] SECURITY_KEY_VALUE = 16'h00A5;

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam logic [2:0] USB_100MA_SLAVE   = 3'h1;
  localparam logic [2:0] USB_500MA_SLAVE   = 3'h5;
  localparam logic [2:0] USB_SUSPEND       = 3'h4;
  localparam logic [2:0] USB_MASTER_LINE   = 3'h2;
  localparam logic [2:0] USB_MASTER_CONV   = 3'h6;
  localparam logic [2:0] CHG_OFF           = 3'h0;
  localparam logic [2:0] CHG_TRICKLE       = 3'h1;
  localparam logic [2:0] CHG_TRICKLE_CHOKE = 3'h2;
  localparam logic [2:0] CHG_TRICKLE_OT    = 3'h3;
  localparam logic [2:0] CHG_FAST          = 3'h4;
  localparam logic [2:0] CHG_FAST_CHOKE    = 3'h6;
  localparam logic [2:0] CHG_FAST_OT       = 3'h5;
  localparam logic [3:0] MAIN_OFF          = 4'h2;
  localparam logic [3:0] MAIN_PRE_ACTIVE   = 4'hD;
  localparam logic [3:0] MAIN_HIBERNATE    = 4'hC;
  localparam logic [3:0] MAIN_ACTIVE       = 4'hF;

  // Control-interface access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pmts_access_type;

  // Converter force-PWM outputs
  typedef struct packed {
    logic buck1_pwm_force;
    logic buck3_pwm_force;
    logic buck4_pwm_force;
  } pmts_pwm_type;

endpackage

//--- pmts_regs.sv
// Debug status and test control register bank; only loop test control is key-protected
// Functional notes
// - USB supply state in status bits 10:8
// - Charger state in bits 6:4, taken live from charger_state_in
// - Main power state in bits 3:0
// - Force bit zeroes track gain until lock
// - Bias 9:8 default 10, pole 7:6 default 00
// - Loop test fields writable only after key
// - Bit 4 forces converter 1/3/4 into PWM
// - Power state machine clears force-PWM bits
`timescale 1ns/1ps

module pmts_regs (
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  input  wire pmts_pkg::pmts_access_type access_in,
  input  wire logic                     key_write_in,
  input  wire logic [15:0]              key_data_in,
  input  wire logic [2:0]               usb_supply_state_in,
  input  wire logic [2:0]               charger_state_in,
  input  wire logic [3:0]               main_power_state_in,
  input  wire logic                     pwm_force_clear_in,
  input  wire logic                     loop_locked_in,
  input  wire logic [3:0]               loop_track_gain_in,
  output logic [15:0]                   rdata_out,
  output logic                          rvalid_out,
  output logic [3:0]                    loop_track_gain_out,
  output logic [1:0]                    loop_bias_ctrl_out,
  output logic [1:0]                    loop_pole_shift_out,
  output logic                          key_unlocked_out,
  output pmts_pkg::pmts_pwm_type        pwm_force_out
);
  import pmts_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic       force_track_gain_zero;
  logic [1:0] loop_bias_ctrl;
  logic [1:0] loop_pole_shift;
  logic       key_unlocked;
  logic [2:0] pwm_force;
  logic       lock_seen;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        sel_status = access_in.addr == ADDR_STATE_MACHINE_STATUS;
  wire        sel_loop   = access_in.addr == ADDR_LOOP_TEST_CONTROL;
  wire        sel_b1     = access_in.addr == ADDR_BUCK1_TEST_CONTROL;
  wire        sel_b3     = access_in.addr == ADDR_BUCK3_TEST_CONTROL;
  wire        sel_b4     = access_in.addr == ADDR_BUCK4_TEST_CONTROL;
  wire        sel_none   = !(sel_status || sel_loop || sel_b1 || sel_b3 || sel_b4);
  wire        wr_loop    = access_in.wr && sel_loop && key_unlocked;
  wire        key_ok     = key_write_in && key_data_in == SECURITY_KEY_VALUE;
  wire [2:0]  pwm_wr     = {3{access_in.wr}} & {sel_b1, sel_b3, sel_b4};
  wire        wbit       = access_in.wdata[PWM_FORCE_BIT];

  // Status word; unused bits are zero and writes never land here
  wire [15:0] status_word = {5'h00, usb_supply_state_in, 1'b0,
                             charger_state_in, main_power_state_in};
  wire [15:0] loop_word   = {3'h0, force_track_gain_zero, 2'h0, loop_bias_ctrl,
                             loop_pole_shift, 6'h00};
  wire [15:0] pwm_word1   = {11'h000, pwm_force[2], 4'h0};
  wire [15:0] pwm_word3   = {11'h000, pwm_force[1], 4'h0};
  wire [15:0] pwm_word4   = {11'h000, pwm_force[0], 4'h0};
  wire [15:0] next_rdata  = sel_status ? status_word :
                            sel_loop   ? loop_word   :
                            sel_b1     ? pwm_word1   :
                            sel_b3     ? pwm_word3   :
                            sel_b4     ? pwm_word4   : 16'h0000;

  // Gain is held at zero only while forcing and lock has not yet been seen
  wire        gain_hold       = force_track_gain_zero && !lock_seen && !loop_locked_in;
  wire [3:0]  next_track_gain = gain_hold ? TRACK_GAIN_ZERO : loop_track_gain_in;

  // ----------------------------------------------------------------
  // Loop test control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      force_track_gain_zero <= FORCE_GAIN_RESET;
      loop_bias_ctrl        <= BIAS_RESET;
      loop_pole_shift       <= POLE_RESET;
      key_unlocked          <= 1'b0;
      lock_seen             <= 1'b0;
    end else begin
      if (key_ok) begin
        key_unlocked <= 1'b1;
      end else if (key_write_in) begin
        key_unlocked <= 1'b0;
      end
      if (wr_loop) begin
        force_track_gain_zero <= access_in.wdata[FORCE_GAIN_BIT];
        loop_bias_ctrl        <= access_in.wdata[BIAS_MSB:BIAS_LSB];
        loop_pole_shift       <= access_in.wdata[POLE_MSB:POLE_LSB];
      end
      // Lock is remembered so a brief drop does not re-zero the gain
      if (loop_locked_in) begin
        lock_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Force-PWM bits; the state machine clear wins over a write
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pwm_force <= {3{PWM_FORCE_RESET}};
    end else if (pwm_force_clear_in) begin
      pwm_force <= {3{PWM_FORCE_RESET}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pwm_wr[i]) begin
          pwm_force[i] <= wbit;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_out           <= 16'h0000;
      rvalid_out          <= 1'b0;
      loop_track_gain_out <= TRACK_GAIN_ZERO;
      loop_bias_ctrl_out  <= BIAS_RESET;
      loop_pole_shift_out <= POLE_RESET;
      key_unlocked_out    <= 1'b0;
      pwm_force_out       <= '0;
    end else begin
      rdata_out           <= access_in.rd ? next_rdata : 16'h0000;
      rvalid_out          <= access_in.rd;
      loop_track_gain_out <= next_track_gain;
      loop_bias_ctrl_out  <= loop_bias_ctrl;
      loop_pole_shift_out <= loop_pole_shift;
      key_unlocked_out    <= key_unlocked;
      pwm_force_out       <= '{buck1_pwm_force: pwm_force[2],
                               buck3_pwm_force: pwm_force[1],
                               buck4_pwm_force: pwm_force[0]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_status_read_fields: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_status |=> rdata_out[10:8] == $past(usb_supply_state_in))
    else $error("usb state readback wrong");
  a_charger_field: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_status |=> rdata_out[6:4] == $past(charger_state_in))
    else $error("charger state readback wrong");
  a_main_field: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_status |=> rdata_out[3:0] == $past(main_power_state_in))
    else $error("main state readback wrong");
  a_status_unused_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_status |=> rdata_out[15:11] == 5'h00 && !rdata_out[7])
    else $error("status unused bits not zero");
  a_gain_held_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    force_track_gain_zero && !lock_seen && !loop_locked_in |=> loop_track_gain_out == 4'h0)
    else $error("track gain not held at zero");
  a_gain_passes: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !force_track_gain_zero |=> loop_track_gain_out == $past(loop_track_gain_in))
    else $error("track gain not passed through");
  a_loop_locked_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_loop && !key_unlocked |=>
      $stable(loop_bias_ctrl) && $stable(loop_pole_shift))
    else $error("loop field changed while locked");
  a_force_locked_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_loop && !key_unlocked |=> $stable(force_track_gain_zero))
    else $error("force bit changed while locked");
  a_bias_after_reset: assert property (@(posedge ref_clk_in)
    $fell(reset_in) |-> loop_bias_ctrl == 2'h2 && loop_pole_shift == 2'h0)
    else $error("loop field reset value wrong");
  a_pwm_force_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_b1 && !pwm_force_clear_in |=> ##1
      pwm_force_out.buck1_pwm_force == $past(wbit, 2))
    else $error("buck1 force bit not written");
  a_pwm_force_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    pwm_force_clear_in |=> ##1 pwm_force_out == '0)
    else $error("force-PWM not cleared");

  // Key-protected loop fields: an unlocked write must land whole, and readback
  // must show the stored fields rather than the last bus data
  a_loop_write_lands: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_loop && key_unlocked |=>
      force_track_gain_zero == $past(access_in.wdata[FORCE_GAIN_BIT]) &&
      loop_bias_ctrl == $past(access_in.wdata[BIAS_MSB:BIAS_LSB]) &&
      loop_pole_shift == $past(access_in.wdata[POLE_MSB:POLE_LSB]))
    else $error("unlocked loop write not stored");
  a_loop_readback: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_loop |=> rdata_out[9:8] == $past(loop_bias_ctrl) &&
      rdata_out[7:6] == $past(loop_pole_shift) &&
      rdata_out[12] == $past(force_track_gain_zero))
    else $error("loop field readback wrong");
  a_loop_out_copy: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    1'b1 |=> loop_bias_ctrl_out == $past(loop_bias_ctrl) &&
      loop_pole_shift_out == $past(loop_pole_shift))
    else $error("loop field outputs stale");
  a_key_opens: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    key_write_in && key_data_in == SECURITY_KEY_VALUE |=> key_unlocked)
    else $error("right key did not unlock");
  a_key_relock: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    key_write_in && key_data_in != SECURITY_KEY_VALUE |=> !key_unlocked)
    else $error("wrong key left bank unlocked");
  a_gain_after_lock: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    loop_locked_in || lock_seen |=> loop_track_gain_out == $past(loop_track_gain_in))
    else $error("track gain not released by lock");

  // Force-PWM paths for the other two converters, the idle hold, buck1 readback and unmapped reads
  a_pwm_b3_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_b3 && !pwm_force_clear_in |=> ##1
      pwm_force_out.buck3_pwm_force == $past(wbit, 2))
    else $error("buck3 force bit not written");
  a_pwm_b4_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.wr && sel_b4 && !pwm_force_clear_in |=> ##1
      pwm_force_out.buck4_pwm_force == $past(wbit, 2))
    else $error("buck4 force bit not written");
  a_pwm_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !pwm_force_clear_in && !(access_in.wr && (sel_b1 || sel_b3 || sel_b4)) |=> $stable(pwm_force))
    else $error("force-PWM bits moved without cause");
  a_pwm_readback: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_b1 |=> rdata_out == {11'h000, $past(pwm_force[2]), 4'h0})
    else $error("buck1 force bit readback wrong");
  a_unmapped_read_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    access_in.rd && sel_none |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");

endmodule

//--- tb_pmts_regs.sv
// Self-checking testbench for the test and status register bank
`timescale 1ns/1ps
module tb_pmts_regs;
  import pmts_pkg::*;
  `define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
  typedef struct packed {
    logic [2:0]  u;
    logic [2:0]  c;
    logic [3:0]  m;
    logic [15:0] e;
  } pmts_row_type;
  pmts_row_type rows [7] = '{'{3'h1, 3'h0, 4'h2, 16'h0102}, '{3'h5, 3'h1, 4'hD, 16'h051D},
    '{3'h4, 3'h2, 4'hC, 16'h042C}, '{3'h2, 3'h3, 4'hF, 16'h023F},
    '{3'h6, 3'h4, 4'h2, 16'h0642}, '{3'h1, 3'h6, 4'hD, 16'h016D},
    '{3'h5, 3'h5, 4'hF, 16'h055F}};
  logic            ref_clk_in = 1'b0;
  logic            reset_in   = 1'b1;
  pmts_access_type acc        = '0;
  logic            key_wr     = 1'b0;
  logic [15:0]     key_dat    = 16'h0000;
  logic [2:0]      usb        = 3'h0;
  logic [2:0]      chg        = 3'h0;
  logic [3:0]      mstate     = 4'h0;
  logic            clr        = 1'b0;
  logic            lock       = 1'b0;
  logic [3:0]      gain_in    = 4'h0;
  logic [15:0]     rdata;
  logic            rvalid;
  logic [3:0]      gain;
  logic [1:0]      bias;
  logic [1:0]      pole;
  logic            unlocked;
  pmts_pwm_type    pwm;
  int              error_cnt  = 0;
  int              num_checks = 0;
  int              cyc        = 0;

  pmts_regs pmts_regs_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .access_in(acc),
    .key_write_in(key_wr), .key_data_in(key_dat), .usb_supply_state_in(usb),
    .charger_state_in(chg), .main_power_state_in(mstate), .pwm_force_clear_in(clr),
    .loop_locked_in(lock), .loop_track_gain_in(gain_in), .rdata_out(rdata),
    .rvalid_out(rvalid), .loop_track_gain_out(gain), .loop_bias_ctrl_out(bias),
    .loop_pole_shift_out(pole), .key_unlocked_out(unlocked), .pwm_force_out(pwm));

  // ----------------------------------------------------------------
  // Clock, watchdog and bus tasks
  // ----------------------------------------------------------------
  always #2 ref_clk_in = ~ref_clk_in;
  // Whole run is about 120 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    acc <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_in);
    acc <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex, input string nm);
    @(posedge ref_clk_in);
    acc <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk_in);
    acc <= '0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK(nm, ex, rdata)
  endtask
  task automatic key(input logic [15:0] v);
    @(posedge ref_clk_in);
    key_wr  <= 1'b1;
    key_dat <= v;
    @(posedge ref_clk_in);
    key_wr <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    gain_in  <= 4'h5;
    tick(3);
    `CHK("bias", 2'h2, bias)
    `CHK("pole", 2'h0, pole)
    `CHK("pwm", 3'h0, pwm)
    `CHK("gain", 4'h0, gain)
    rd(ADDR_STATE_MACHINE_STATUS, 16'h0000, "status reset");
    rd(ADDR_LOOP_TEST_CONTROL, 16'h1200, "loop reset");
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk_in);
      {usb, chg, mstate} <= {rows[i].u, rows[i].c, rows[i].m};
      rd(ADDR_STATE_MACHINE_STATUS, rows[i].e, "status");
    end
    wr(ADDR_STATE_MACHINE_STATUS, 16'hFFFF);
    rd(ADDR_STATE_MACHINE_STATUS, 16'h055F, "status ro");
    $display("test status done");
    // Key protection and loop fields; lock stays low so gain follows only the force bit
    wr(ADDR_LOOP_TEST_CONTROL, 16'h0000);
    rd(ADDR_LOOP_TEST_CONTROL, 16'h1200, "loop locked");
    key(SECURITY_KEY_VALUE);
    tick(2);
    `CHK("unlock", 1'b1, unlocked)
    wr(ADDR_LOOP_TEST_CONTROL, 16'hFFFF);
    rd(ADDR_LOOP_TEST_CONTROL, 16'h13C0, "loop all");
    tick(1);
    `CHK("bias out", 2'h3, bias)
    `CHK("pole out", 2'h3, pole)
    `CHK("gain forced", 4'h0, gain)
    wr(ADDR_LOOP_TEST_CONTROL, 16'h0000);
    tick(3);
    `CHK("gain free", 4'h5, gain)
    key(16'h0000);
    tick(2);
    `CHK("relock", 1'b0, unlocked)
    wr(ADDR_LOOP_TEST_CONTROL, 16'hFFFF);
    rd(ADDR_LOOP_TEST_CONTROL, 16'h0000, "loop relocked");
    // Mid-run reset brings the force bit back, then lock releases the gain
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    tick(2);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    tick(3);
    `CHK("gain rst", 4'h0, gain)
    @(posedge ref_clk_in);
    lock <= 1'b1;
    tick(3);
    `CHK("gain lock", 4'h5, gain)
    @(posedge ref_clk_in);
    lock    <= 1'b0;
    gain_in <= 4'h9;
    tick(3);
    `CHK("gain kept", 4'h9, gain)
    $display("test loop done");
    // Force-PWM set, selective clear, hardware clear and clear against a write
    wr(ADDR_BUCK1_TEST_CONTROL, 16'h0010);
    wr(ADDR_BUCK3_TEST_CONTROL, 16'h0010);
    wr(ADDR_BUCK4_TEST_CONTROL, 16'h0010);
    tick(2);
    `CHK("pwm all", 3'h7, pwm)
    rd(ADDR_BUCK1_TEST_CONTROL, 16'h0010, "buck1");
    wr(ADDR_BUCK3_TEST_CONTROL, 16'h0000);
    tick(2);
    `CHK("pwm b3 off", 3'h5, pwm)
    @(posedge ref_clk_in);
    clr <= 1'b1;
    @(posedge ref_clk_in);
    clr <= 1'b0;
    tick(2);
    `CHK("pwm hw clr", 3'h0, pwm)
    rd(ADDR_BUCK4_TEST_CONTROL, 16'h0000, "buck4");
    @(posedge ref_clk_in);
    acc <= '{1'b1, 1'b0, ADDR_BUCK1_TEST_CONTROL, 16'h0010};
    clr <= 1'b1;
    @(posedge ref_clk_in);
    acc <= '0;
    clr <= 1'b0;
    tick(3);
    `CHK("pwm clr wins", 3'h0, pwm)
    rd(8'h00, 16'h0000, "unmapped");
    $display("test pwm done");
    print_verdict();
  end
endmodule
